// *** verilog/slalc_top.sv ***
// Strap latch, configuration decode and indicator driver with its register port.
//
// Functional notes
// - Copper straps 110 force 100 Mb/s full duplex, straight pairs.
// - Copper straps 111 force 100 Mb/s full duplex crossed; 011, 100, 101 invalid.
// - Fiber modes: low select 1 enables signal detect input, 0 disables it.
// - Bridge mode, port-swap 0: SGMII faces MAC, RGMII is PHY side.
// - Bridge mode, port-swap 1: RGMII faces MAC, SGMII is PHY side.
// - 100M converter, selects 00: copper autoneg advertising 100/10, auto crossover.
// - 100M converter, selects 11: copper autoneg advertising 100 only, auto crossover.
// - Converters: link-loss strap 0 enables pass-through, 1 disables it.
// - 1000M converter, selects 00: copper autoneg advertising 1000/100, auto crossover.
// - 1000M converter, selects 11: copper autoneg advertising 1000 only.
// - 1000M converter never falls back to 100 Mb/s; link fails instead.
// - Three indicators, defaults from mode strap, selectable by register 18h.
// - Each indicator polarity follows the level its strap sampled at reset.
// - Strap sampled low gives an active-high indicator.
// - Strap sampled high gives an active-low indicator.
// - Bridge with forced speeds: link indicator function is unavailable.
// - Bridge modes: transmit or receive activity refers to the RGMII side.
// - 1000M converter: link indicator shows a 1000 Mb/s copper link only.
// - 100M converter: link indicator shows a 100 Mb/s copper link only.
// - Reset low for at least 1 us restores defaults and re-latches all straps.
// - Global software reset restores register defaults but keeps latched straps.
module slalc_top
   import slalc_pkg::*;
#(
   parameter int BLINK_HALF = BLINK_HALF_CYC
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Strap pins
   input  wire logic [2:0]  i_ind_pad,
   input  wire logic [2:0]  i_function_mode_strap,
   input  wire logic        i_port_swap_strap,
   input  wire logic        i_link_loss_strap,
   // Indicator drivers
   output logic [2:0]       o_ind_out,
   output logic [2:0]       o_ind_oe_n,
   // Link status from the datapath
   input  wire logic        i_copper_link,
   input  wire logic [1:0]  i_copper_speed,
   input  wire logic        i_copper_full_dup,
   input  wire logic        i_fiber_link,
   input  wire logic        i_sgmii_link,
   input  wire logic [1:0]  i_sgmii_speed,
   input  wire logic        i_speed_forced,
   input  wire logic        i_rgmii_tx_act,
   input  wire logic        i_rgmii_rx_act,
   input  wire logic        i_media_tx_act,
   input  wire logic        i_media_rx_act,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   // Latched configuration
   output slalc_cfg_s       o_cfg,
   output logic             o_straps_valid
);

   localparam int BW = $clog2(BLINK_HALF + 1);
   localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYC - 1);
   localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF - 1);

   logic          rst_m_q;
   logic          rst_n_q;
   logic [7:0]    pad_m_q;
   logic [7:0]    pad_s_q;
   slalc_state_e  state_q;
   slalc_state_e  state_d;
   logic [1:0]    cnt_q;
   slalc_straps_s straps_q;
   logic [2:0]    pol_q;
   logic [15:0]   ind_sel_q;
   slalc_cfg_s    cfg_q;
   slalc_cfg_s    cfg_d;
   logic          valid_q;
   logic [15:0]   rdata_q;
   logic [2:0]    ind_out_q;
   logic [2:0]    oe_n_q;
   logic [BW-1:0] blink_cnt_q;
   logic          blink_q;
   logic [15:0]   fn_src;
   logic [2:0]    ind_act;

   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // Strap pins are asynchronous to the clock and pass two flops.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pad_m_q <= 8'h00;
         pad_s_q <= 8'h00;
      end else begin
         pad_m_q <= {i_link_loss_strap, i_port_swap_strap, i_function_mode_strap, i_ind_pad};
         pad_s_q <= pad_m_q;
      end
   end

   // Straps are sampled only while the indicator drivers are off, so the pads
   // show the resistor level and not our own drive.
   wire settle_done = (state_q == ST_SETTLE) && (cnt_q == SETTLE_LAST);
   wire run         = (state_q == ST_RUN);

   always_comb begin
      case (state_q)
         ST_HOLD:   state_d = ST_SETTLE;
         ST_SETTLE: state_d = settle_done ? ST_RUN : ST_SETTLE;
         ST_RUN:    state_d = ST_RUN;
         default:   state_d = ST_HOLD;
      endcase
   end

   // A hardware reset returns to hold and forces a fresh latch.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_HOLD;
         cnt_q   <= 2'b00;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_q == ST_SETTLE) ? cnt_q + 2'b01 : 2'b00;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         straps_q <= '0;
         pol_q    <= 3'b000;
      end else if (settle_done) begin
         straps_q <= pad_s_q;
         pol_q    <= pad_s_q[2:0];
      end
   end

   wire slalc_mode_e mode     = straps_q.mode;
   wire [1:0]        sel2     = {straps_q.sel_high, straps_q.sel_low};
   wire [2:0]        cu_code  = {straps_q.autoneg_disable_strap, sel2};
   wire              is_cu    = (mode == MODE_RGMII_CU) || (mode == MODE_SGMII_CU);
   wire              is_fx    = (mode == MODE_RGMII_1KX) || (mode == MODE_RGMII_100FX);
   wire              is_conv  = (mode == MODE_CONV_1G) || (mode == MODE_CONV_100M);
   wire              is_brg   = (mode == MODE_BRIDGE);
   wire              fiber_gig = (mode == MODE_RGMII_1KX) || (mode == MODE_CONV_1G);

   always_comb begin
      cfg_d = '0;
      if (is_cu) begin
         case (cu_code)
            3'b000: {cfg_d.aneg_en, cfg_d.auto_mdix, cfg_d.adv_1000, cfg_d.adv_100,
                     cfg_d.adv_10} = 5'h1F;
            3'b001: {cfg_d.aneg_en, cfg_d.auto_mdix, cfg_d.adv_1000, cfg_d.adv_100} = 4'hF;
            3'b010: {cfg_d.aneg_en, cfg_d.auto_mdix, cfg_d.adv_100, cfg_d.adv_10} = 4'hF;
            3'b110: cfg_d.force_100_fd = 1'b1;
            3'b111: {cfg_d.force_100_fd, cfg_d.mdix_forced} = 2'b11;
            default: cfg_d.strap_invalid = 1'b1;
         endcase
      end
      if (is_cu || is_conv) begin
         cfg_d.mirror_en = straps_q.port_swap;
      end
      if (fiber_gig) begin
         cfg_d.fiber_aneg_en = !straps_q.autoneg_disable_strap;
      end
      if (is_fx) begin
         cfg_d.sig_det_en = straps_q.sel_low;
      end
      if (is_brg) begin
         cfg_d.rgmii_mac_side = straps_q.port_swap;
      end
      if (is_conv) begin
         cfg_d.link_loss_pt_en = !straps_q.link_loss;
         cfg_d.aneg_en   = 1'b1;
         cfg_d.auto_mdix = 1'b1;
         cfg_d.no_downgrade = (mode == MODE_CONV_1G);
         case ({mode == MODE_CONV_1G, sel2})
            3'b000: {cfg_d.adv_100, cfg_d.adv_10} = 2'b11;
            3'b011: cfg_d.adv_100 = 1'b1;
            3'b100: {cfg_d.adv_1000, cfg_d.adv_100} = 2'b11;
            3'b111: cfg_d.adv_1000 = 1'b1;
            default: cfg_d.strap_invalid = 1'b1;
         endcase
      end
   end

   // Register port decode.
   wire swrst    = i_wr && (i_addr == CTRL_OFS) && i_wdata[CTRL_SWRST_BIT];
   wire wr_sel   = i_wr && (i_addr == IND_SEL_OFS);
   wire [15:0] sts = {6'h00, valid_q, cfg_q.strap_invalid, straps_q};
   wire [15:0] rd_mux = (i_addr == IND_SEL_OFS)   ? ind_sel_q :
                        (i_addr == STRAP_STS_OFS) ? sts : RDATA_IDLE;

   // Software reset reloads the mode default but leaves the latched straps alone.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ind_sel_q <= ind_default(MODE_JTAG);
      end else if (settle_done) begin
         ind_sel_q <= ind_default(slalc_mode_e'(pad_s_q[5:3]));
      end else if (swrst) begin
         ind_sel_q <= ind_default(mode);
      end else if (wr_sel) begin
         ind_sel_q <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_q   <= '0;
         valid_q <= 1'b0;
         rdata_q <= RDATA_IDLE;
      end else begin
         cfg_q   <= run ? cfg_d : '0;
         valid_q <= run;
         rdata_q <= i_rd ? rd_mux : RDATA_IDLE;
      end
   end

   // Blink for a copper link at the wrong speed or duplex in the converters.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end else begin
         blink_cnt_q <= (blink_cnt_q == BLINK_LAST) ? '0 : blink_cnt_q + 1'b1;
         blink_q     <= (blink_cnt_q == BLINK_LAST) ? !blink_q : blink_q;
      end
   end

   // Converter link only counts at the converter's own copper speed.
   wire [1:0] conv_spd = (mode == MODE_CONV_1G) ? SPD_1000 : SPD_100;
   wire cu_at_spd = i_copper_link && (i_copper_speed == conv_spd);
   wire link_gone = is_brg && i_speed_forced;
   wire link_any  = is_brg  ? i_sgmii_link :
                    is_fx   ? i_fiber_link :
                    is_conv ? cu_at_spd : i_copper_link;
   wire link_1g   = is_brg ? (i_sgmii_link && (i_sgmii_speed == SPD_1000)) :
                             (i_copper_link && (i_copper_speed == SPD_1000));
   wire tx_act    = is_brg ? i_rgmii_tx_act : i_media_tx_act;
   wire rx_act    = is_brg ? i_rgmii_rx_act : i_media_rx_act;
   wire cu_check  = i_copper_link && ((cu_at_spd && i_copper_full_dup) || blink_q);

   always_comb begin
      fn_src                = 16'h0000;
      fn_src[FN_LINK]       = link_any && !link_gone;
      fn_src[FN_LINK_1G]    = link_1g && !link_gone;
      fn_src[FN_ACT]        = tx_act || rx_act;
      fn_src[FN_ACT_RX]     = rx_act;
      fn_src[FN_ACT_TX]     = tx_act;
      fn_src[FN_FIBER_LINK] = i_fiber_link;
      fn_src[FN_CU_CHECK]   = cu_check;
   end

   for (genvar gi = 0; gi < 3; gi++) begin : g_ind
      assign ind_act[gi] = fn_src[ind_sel_q[gi*IND_FN_W +: IND_FN_W]];
   end

   // A high strap inverts the driver so the lamp sits against the pull-up.
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ind_out_q <= 3'b000;
         oe_n_q    <= 3'b111;
      end else begin
         ind_out_q <= run ? (ind_act ^ pol_q) : 3'b000;
         oe_n_q    <= run ? 3'b000 : 3'b111;
      end
   end

   assign o_ind_out      = ind_out_q;
   assign o_ind_oe_n     = oe_n_q;
   assign o_rdata        = rdata_q;
   assign o_cfg          = cfg_q;
   assign o_straps_valid = valid_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n_q);

   sequence s_cu_code(logic [2:0] v);
      run && is_cu && (cu_code == v);
   endsequence
   sequence s_forced(logic x);
      o_cfg.force_100_fd && !o_cfg.aneg_en && (o_cfg.mdix_forced == x);
   endsequence

   a_latch_after_reset: assert property (
      (state_q == ST_HOLD) |-> ##[1:4] run)
      else $error("straps not latched after reset release");
   a_swrst_keeps_straps: assert property (
      (run && swrst) |=> $stable(straps_q) && (ind_sel_q == ind_default(straps_q.mode)))
      else $error("software reset changed straps or missed defaults");
   a_drive_after_latch: assert property (
      run |=> (o_ind_oe_n == 3'b000))
      else $error("indicator not driven after latch");
   a_pol_active_high: assert property (
      (run && !pol_q[0]) |=> (o_ind_out[0] == $past(ind_act[0])))
      else $error("low strap did not give active-high indicator");
   a_pol_active_low: assert property (
      (run && pol_q[1]) |=> (o_ind_out[1] == !$past(ind_act[1])))
      else $error("high strap did not give active-low indicator");
   a_forced_mdi: assert property (
      s_cu_code(3'b110) |=> s_forced(1'b0))
      else $error("forced straight mode not set");
   a_forced_mdix: assert property (
      s_cu_code(3'b111) |=> s_forced(1'b1))
      else $error("forced crossed mode not set");
   a_bridge_side: assert property (
      (run && is_brg) |=> (o_cfg.rgmii_mac_side == $past(straps_q.port_swap)))
      else $error("bridge direction does not follow port swap strap");
   a_link_loss_pass: assert property (
      (run && is_conv) |=> (o_cfg.link_loss_pt_en == !$past(straps_q.link_loss)))
      else $error("link loss pass-through wrong");
   a_gig_conv_advert: assert property (
      (run && (mode == MODE_CONV_1G) && (sel2 == 2'b00)) |=>
      (o_cfg.adv_1000 && o_cfg.adv_100 && !o_cfg.adv_10 && o_cfg.no_downgrade))
      else $error("gigabit converter advert wrong");
   a_bridge_tx_act: assert property (
      (run && is_brg && !pol_q[2] && (ind_sel_q[11:8] == FN_ACT_TX)) |=>
      (o_ind_out[2] == $past(i_rgmii_tx_act)))
      else $error("bridge activity not from RGMII side");
   a_forced_no_link: assert property (
      (run && link_gone && !pol_q[0] && (ind_sel_q[3:0] == FN_LINK)) |=> !o_ind_out[0])
      else $error("link indicator active with forced bridge speed");

   // Advertised abilities one edge after the decode that produced them.
   sequence s_advert(logic a1000, logic a100, logic a10);
      o_cfg.aneg_en && o_cfg.auto_mdix && (o_cfg.adv_1000 == a1000) &&
      (o_cfg.adv_100 == a100) && (o_cfg.adv_10 == a10);
   endsequence
   sequence s_conv_sel(logic gig, logic [1:0] v);
      run && is_conv && ((mode == MODE_CONV_1G) == gig) && (sel2 == v);
   endsequence

   a_cu_full_advert: assert property (
      s_cu_code(3'b000) |=> s_advert(1'b1, 1'b1, 1'b1))
      else $error("copper full advert wrong");
   a_cu_gig_advert: assert property (
      s_cu_code(3'b001) |=> s_advert(1'b1, 1'b1, 1'b0))
      else $error("copper gigabit advert wrong");
   a_cu_fast_advert: assert property (
      s_cu_code(3'b010) |=> s_advert(1'b0, 1'b1, 1'b1))
      else $error("copper fast advert wrong");
   a_cu_invalid_flag: assert property (
      (run && is_cu && (cu_code inside {3'b011, 3'b100, 3'b101})) |=> o_cfg.strap_invalid)
      else $error("invalid copper straps not flagged");
   a_mirror_follows: assert property (
      (run && (is_cu || is_conv)) |=> (o_cfg.mirror_en == $past(straps_q.port_swap)))
      else $error("mirroring does not follow port swap strap");
   a_fiber_aneg: assert property (
      (run && fiber_gig) |=> (o_cfg.fiber_aneg_en == !$past(straps_q.autoneg_disable_strap)))
      else $error("fiber autoneg does not follow strap");
   a_sig_detect: assert property (
      (run && is_fx) |=> (o_cfg.sig_det_en == $past(straps_q.sel_low)))
      else $error("signal detect does not follow strap");
   a_bridge_default: assert property (
      (run && is_brg && !straps_q.port_swap) |=> !o_cfg.rgmii_mac_side)
      else $error("bridge default direction wrong");
   a_fast_conv_both: assert property (
      s_conv_sel(1'b0, 2'b00) |=> s_advert(1'b0, 1'b1, 1'b1))
      else $error("fast converter advert wrong");
   a_fast_conv_only: assert property (
      s_conv_sel(1'b0, 2'b11) |=> s_advert(1'b0, 1'b1, 1'b0))
      else $error("fast converter single advert wrong");
   a_gig_conv_only: assert property (
      s_conv_sel(1'b1, 2'b11) |=> s_advert(1'b1, 1'b0, 1'b0))
      else $error("gigabit converter single advert wrong");
   a_no_downgrade: assert property (
      (run && is_conv) |=> (o_cfg.no_downgrade == $past(mode == MODE_CONV_1G)))
      else $error("downgrade lock wrong");
   a_sel_default: assert property (
      settle_done |=> (ind_sel_q == ind_default(straps_q.mode)))
      else $error("indicator functions not defaulted at latch");
   a_conv_link_speed: assert property (
      (run && is_conv && !cu_at_spd && !pol_q[0] && (ind_sel_q[3:0] == FN_LINK)) |=> !o_ind_out[0])
      else $error("converter link shown at wrong speed");
   a_released_in_latch: assert property (
      !run |=> (o_ind_oe_n == 3'b111))
      else $error("indicator driven before straps latched");

endmodule : slalc_top

// *** verilog/slalc_pkg.sv ***
// Register map, strap encodings, indicator functions and timing for the strap latch block.
package slalc_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0]  IND_SEL_OFS    = 8'h18;
   localparam logic [7:0]  CTRL_OFS       = 8'h1F;
   localparam logic [7:0]  STRAP_STS_OFS  = 8'h6E;
   localparam int          CTRL_SWRST_BIT = 15;
   localparam int          IND_FN_W       = 4;
   localparam logic [15:0] RDATA_IDLE     = 16'h0000;

   // Timing.
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RESET_MIN_NS   = 1000;
   localparam int RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC     = 2;
   localparam int BLINK_HALF_MS  = 50;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

   // Copper speed codes reported by the datapath.
   localparam logic [1:0] SPD_100  = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;

   typedef enum logic [2:0] {
      MODE_RGMII_CU   = 3'h0,
      MODE_RGMII_1KX  = 3'h1,
      MODE_RGMII_100FX = 3'h2,
      MODE_BRIDGE     = 3'h3,
      MODE_CONV_1G    = 3'h4,
      MODE_CONV_100M  = 3'h5,
      MODE_SGMII_CU   = 3'h6,
      MODE_JTAG       = 3'h7
   } slalc_mode_e;

   typedef enum logic [3:0] {
      FN_LINK       = 4'h0,
      FN_LINK_1G    = 4'h1,
      FN_ACT        = 4'h2,
      FN_ACT_RX     = 4'h3,
      FN_ACT_TX     = 4'h4,
      FN_FIBER_LINK = 4'h5,
      FN_CU_CHECK   = 4'h6,
      FN_OFF        = 4'hF
   } slalc_indfn_e;

   typedef enum logic [1:0] {
      ST_HOLD   = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b11
   } slalc_state_e;

   typedef struct packed {
      logic        link_loss;
      logic        port_swap;
      slalc_mode_e mode;
      logic        sel_high;
      logic        sel_low;
      logic        autoneg_disable_strap;
   } slalc_straps_s;

   typedef struct packed {
      logic aneg_en;
      logic auto_mdix;
      logic mdix_forced;
      logic adv_1000;
      logic adv_100;
      logic adv_10;
      logic force_100_fd;
      logic mirror_en;
      logic fiber_aneg_en;
      logic sig_det_en;
      logic rgmii_mac_side;
      logic link_loss_pt_en;
      logic no_downgrade;
      logic strap_invalid;
   } slalc_cfg_s;

   // Default indicator functions, fields 0..2 low to high, top field unused.
   function automatic logic [15:0] ind_default(slalc_mode_e m);
      case (m)
         MODE_RGMII_CU, MODE_SGMII_CU, MODE_BRIDGE:
            ind_default = {FN_OFF, FN_ACT, FN_LINK_1G, FN_LINK};
         MODE_RGMII_1KX, MODE_RGMII_100FX:
            ind_default = {FN_OFF, FN_ACT_RX, FN_ACT_RX, FN_FIBER_LINK};
         MODE_CONV_1G, MODE_CONV_100M:
            ind_default = {FN_OFF, FN_ACT, FN_FIBER_LINK, FN_CU_CHECK};
         default:
            ind_default = {FN_OFF, FN_OFF, FN_OFF, FN_OFF};
      endcase
   endfunction : ind_default

endpackage : slalc_pkg

// *** tb/slalc_strap_model.sv ***
// Strap resistors and indicator lamps that sit on the three shared indicator pins.
module slalc_strap_model (
   // Resistor levels chosen by the bench
   input  wire logic [2:0] i_pull,
   // Pin drive from the block
   input  wire logic [2:0] i_drive,
   input  wire logic [2:0] i_oe_n,
   // Pin level and lamp state
   output logic [2:0]      o_pad,
   output logic [2:0]      o_lit
);
   timeunit 1ns;
   timeprecision 1ps;

   // A released pin settles to its resistor level, which is what the block samples.
   assign o_pad = (i_drive & ~i_oe_n) | (i_pull & i_oe_n);
   // The lamp hangs towards the same rail as its resistor, so it lights on the other level.
   assign o_lit = ~i_oe_n & (i_drive ^ i_pull);
endmodule : slalc_strap_model

// *** tb/slalc_tb.sv ***
// Self-checking bench for strap capture, decoded configuration and indicator drive.
module slalc_tb;
   import slalc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [2:0]  pull = 3'h0;
   logic [2:0]  mode_s = 3'h0;
   logic        swap_s = 1'b0;
   logic        ll_s = 1'b0;
   logic [12:0] st = 13'h0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd_s = 1'b0;
   logic [2:0]  pad;
   logic [2:0]  lit;
   logic [2:0]  drv;
   logic [2:0]  oe_n;
   logic [15:0] rdata;
   slalc_cfg_s  cfg;
   logic        valid;
   int          err_total = 0;
   int          checked = 0;
   localparam int BLINK_T = 4;

   always #5 clk = ~clk;

   slalc_top #(.BLINK_HALF(BLINK_T)) dut_u (
      .i_clk(clk), .i_resetn(resetn), .i_ind_pad(pad), .i_function_mode_strap(mode_s),
      .i_port_swap_strap(swap_s), .i_link_loss_strap(ll_s), .o_ind_out(drv),
      .o_ind_oe_n(oe_n), .i_copper_link(st[0]), .i_copper_speed(st[2:1]),
      .i_copper_full_dup(st[3]), .i_fiber_link(st[4]), .i_sgmii_link(st[5]),
      .i_sgmii_speed(st[7:6]), .i_speed_forced(st[8]), .i_rgmii_tx_act(st[9]),
      .i_rgmii_rx_act(st[10]), .i_media_tx_act(st[11]), .i_media_rx_act(st[12]),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata),
      .o_cfg(cfg), .o_straps_valid(valid)
   );

   slalc_strap_model strap_u (
      .i_pull(pull), .i_drive(drv), .i_oe_n(oe_n), .o_pad(pad), .o_lit(lit)
   );

   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         err_total++;
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   function automatic logic [15:0] dflt(input logic [2:0] m);
      case (m)
         3'h1, 3'h2: dflt = 16'hF335;
         3'h4, 3'h5: dflt = 16'hF256;
         3'h7: dflt = 16'hFFFF;
         default: dflt = 16'hF210;
      endcase
   endfunction : dflt

   task automatic latch(input logic [2:0] p, input logic [2:0] m, input logic sw,
                        input logic ll);
      int n;
      @(posedge clk);
      resetn <= 1'b0;
      pull <= p;
      mode_s <= m;
      swap_s <= sw;
      ll_s <= ll;
      repeat (RESET_MIN_CYC) @(posedge clk);
      chk({13'h0, oe_n}, 16'h0007);
      resetn <= 1'b1;
      n = 0;
      while (valid !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n == 40) begin
         err_total++;
         print_verdict();
      end
      @(posedge clk);
   endtask : latch

   // Invalid combinations only promise the invalid flag, so only that bit is compared.
   task automatic run_case(input logic [2:0] p, input logic [2:0] m, input logic sw,
                           input logic ll, input logic [13:0] exp, input logic inv_only);
      latch(p, m, sw, ll);
      if (inv_only) begin
         chk({15'h0, cfg.strap_invalid}, 16'h0001);
      end else begin
         chk({2'h0, cfg}, {2'h0, exp});
      end
      rd_chk(STRAP_STS_OFS, {6'h0, 1'b1, exp[0], ll, sw, m, p});
      rd_chk(IND_SEL_OFS, dflt(m));
   endtask : run_case

   // Settle time covers the register write and the one-cycle status pipeline.
   task automatic ind_case(input logic [15:0] word, input logic [12:0] stat,
                           input logic [2:0] act);
      wr_reg(IND_SEL_OFS, word);
      st <= stat;
      repeat (3) @(posedge clk);
      #1;
      chk({13'h0, lit}, {13'h0, act});
   endtask : ind_case

   // The blink runs free, so any window of two half periods shows exactly one lit half.
   task automatic blink_chk(input logic [12:0] stat);
      int ones;
      @(posedge clk);
      st <= stat;
      ones = 0;
      repeat (3) @(posedge clk);
      repeat (2 * BLINK_T) begin
         @(posedge clk);
         #1;
         if (lit[0] === 1'b1) begin
            ones++;
         end
      end
      chk(16'(ones), 16'(BLINK_T));
   endtask : blink_chk

   initial begin
      repeat (3) @(posedge clk);
      run_case(3'h0, 3'h0, 1'b0, 1'b0, 14'h3700, 1'b0);
      ind_case(16'h6F34, 13'h0800, 3'h1);
      rd_chk(IND_SEL_OFS, 16'h6F34);
      wr_reg(CTRL_OFS, 16'h0000);
      rd_chk(IND_SEL_OFS, 16'h6F34);
      wr_reg(CTRL_OFS, 16'h8000);
      rd_chk(IND_SEL_OFS, 16'hF210);
      chk({1'b0, valid, cfg}, 16'h7700);
      wr_reg(8'h20, 16'hFFFF);
      rd_chk(8'h20, 16'h0000);
      run_case(3'h2, 3'h0, 1'b1, 1'b0, 14'h3640, 1'b0);
      run_case(3'h4, 3'h6, 1'b0, 1'b0, 14'h3300, 1'b0);
      run_case(3'h5, 3'h0, 1'b0, 1'b0, 14'h0080, 1'b0);
      run_case(3'h7, 3'h0, 1'b0, 1'b0, 14'h0880, 1'b0);
      ind_case(16'hF210, 13'h000D, 3'h3);
      run_case(3'h6, 3'h0, 1'b0, 1'b0, 14'h0001, 1'b1);
      run_case(3'h1, 3'h6, 1'b0, 1'b0, 14'h0001, 1'b1);
      run_case(3'h3, 3'h0, 1'b0, 1'b0, 14'h0001, 1'b1);
      run_case(3'h2, 3'h1, 1'b0, 1'b0, 14'h0030, 1'b0);
      run_case(3'h1, 3'h1, 1'b0, 1'b0, 14'h0000, 1'b0);
      run_case(3'h2, 3'h2, 1'b0, 1'b0, 14'h0010, 1'b0);
      run_case(3'h0, 3'h3, 1'b0, 1'b0, 14'h0000, 1'b0);
      run_case(3'h0, 3'h3, 1'b1, 1'b0, 14'h0008, 1'b0);
      ind_case(16'hF430, 13'h0DA1, 3'h2);
      ind_case(16'hF430, 13'h0CA1, 3'h3);
      ind_case(16'hF430, 13'h02A1, 3'h5);
      run_case(3'h0, 3'h4, 1'b0, 1'b0, 14'h3626, 1'b0);
      ind_case(16'hFFF0, 13'h000D, 3'h1);
      ind_case(16'hFFF0, 13'h000B, 3'h0);
      run_case(3'h7, 3'h4, 1'b1, 1'b1, 14'h3442, 1'b0);
      run_case(3'h0, 3'h5, 1'b0, 1'b0, 14'h3304, 1'b0);
      ind_case(16'hFFF0, 13'h000B, 3'h1);
      ind_case(16'hFFF0, 13'h000D, 3'h0);
      ind_case(16'hF256, 13'h101B, 3'h7);
      blink_chk(13'h000D);
      run_case(3'h6, 3'h5, 1'b1, 1'b1, 14'h3240, 1'b0);
      run_case(3'h2, 3'h5, 1'b0, 1'b0, 14'h0001, 1'b1);
      print_verdict();
   end
endmodule : slalc_tb
